// file: irq_map_pkg.sv
package irq_map_pkg;

  // request lines and level fields
  localparam int NUM_REQ = 24;
  localparam int LVL_W = 2;
  localparam int NUM_LVL_REG = 6;
  localparam int FIELDS_PER_REG = 4;
  localparam int NUM_EXT = 12;
  localparam int NUM_W = 5;

  // level register block on the core's data bus
  localparam logic [15:0] LVL_BASE_ADDR = 16'h0079;
  localparam logic [7:0] LVL_RESET = 8'hff;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
  localparam logic [2:0] LVL_REG_IDX_W = 3'h0;

  // vector table: first entry, descending two bytes per request
  localparam logic [15:0] VEC_TOP = 16'hfffa;

  // request numbers of the fixed sources
  localparam logic [4:0] REQ_EXT_B = 5'h00;
  localparam logic [4:0] REQ_SERIAL = 5'h04;
  localparam logic [4:0] REQ_CT0_LO = 5'h05;
  localparam logic [4:0] REQ_CT0_HI = 5'h06;
  localparam logic [4:0] REQ_LIN_RX = 5'h07;
  localparam logic [4:0] REQ_LIN_TX = 5'h08;
  localparam logic [4:0] REQ_PG1_LO = 5'h09;
  localparam logic [4:0] REQ_PG1_HI = 5'h0a;
  localparam logic [4:0] REQ_RELOAD = 5'h0b;
  localparam logic [4:0] REQ_PG0_HI = 5'h0c;
  localparam logic [4:0] REQ_PG0_LO = 5'h0d;
  localparam logic [4:0] REQ_CT1_HI = 5'h0e;
  localparam logic [4:0] REQ_P16_0 = 5'h0f;
  localparam logic [4:0] REQ_I2C = 5'h10;
  localparam logic [4:0] REQ_P16_1 = 5'h11;
  localparam logic [4:0] REQ_ADC = 5'h12;
  localparam logic [4:0] REQ_TIMEBASE = 5'h13;
  localparam logic [4:0] REQ_WATCH = 5'h14;
  localparam logic [4:0] REQ_EXT_HI = 5'h15;
  localparam logic [4:0] REQ_CT1_LO = 5'h16;
  localparam logic [4:0] REQ_FLASH = 5'h17;

  // peripheral request levels, all on the system clock
  typedef struct packed {
    logic [11:0] ext;
    logic serial;
    logic ct0_lo;
    logic ct0_hi;
    logic lin_rx;
    logic lin_tx;
    logic pg1_lo;
    logic pg1_hi;
    logic reload;
    logic pg0_hi;
    logic pg0_lo;
    logic ct1_hi;
    logic p16_0;
    logic i2c;
    logic p16_1;
    logic adc;
    logic timebase;
    logic watch;
    logic ct1_lo;
    logic flash;
  } src_t;

  // vectored request toward the core
  typedef struct packed {
    logic valid;
    logic [4:0] num;
    logic [1:0] level;
    logic [15:0] vector;
  } grant_t;

endpackage

// file: prio_pick.sv
`timescale 1ns/1ps
module prio_pick
  import irq_map_pkg::*;
(
  // pending requests and their level fields
  input wire logic [NUM_REQ-1:0] req,
  input wire logic [NUM_REQ*LVL_W-1:0] lvl_flat,
  // winner
  output logic found,
  output logic [NUM_W-1:0] num,
  output logic [LVL_W-1:0] level
);

  // ascending scan with strict compare: ties keep the lower number
  always_comb begin
    found = 1'b0;
    num = '0;
    level = '1;
    for (int n = 0; n < NUM_REQ; n++) begin
      if (req[n] && (!found || lvl_flat[n*LVL_W +: LVL_W] < level)) begin
        found = 1'b1;
        num = NUM_W'(n);
        level = lvl_flat[n*LVL_W +: LVL_W];
      end
    end
  end

endmodule // prio_pick

// file: irq_vector_map.sv
// Notes on behaviour
// - Among pending requests at one level the lowest request number wins.
// - Every one of the 24 requests has its own 2-bit level field, in order.
// - Compound timer 0 lower raises request 5 and upper raises request 6.
// - Compound timer 1 upper raises request 14 and lower raises request 22.
// - Pulse generator ch1 lower/upper on 9/10, ch0 upper/lower on 12/13.
// - Other sources sit on 4, 7, 8, 11 and 15 to 20, flash on 23.
// - Unassigned addresses are not written by software and read as a fixed 00.
// - Six 8-bit level registers from 0079, each resetting to all ones.
`timescale 1ns/1ps
module irq_vector_map
  import irq_map_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // peripheral requests
  input wire src_t src,
  // core data bus toward the level registers
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata_q,
  // vectored request toward the core
  output grant_t grant_q
);

  logic [7:0] lvl_q [NUM_LVL_REG];
  logic [NUM_REQ*LVL_W-1:0] lvl_flat;
  logic [NUM_REQ-1:0] req_vec;
  logic [15:0] addr_off;
  logic addr_hit;
  logic [2:0] addr_idx;
  logic pick_found;
  logic [NUM_W-1:0] pick_num;
  logic [LVL_W-1:0] pick_level;
  grant_t grant_d;

  // external pairs share the four top request lines
  genvar g;
  generate
    for (g = 0; g < FIELDS_PER_REG; g++) begin : g_ext
      assign req_vec[REQ_EXT_B + g] = src.ext[g] | src.ext[g + 4];
    end
  endgenerate
  // channels 8 to 11 merge into one line
  assign req_vec[REQ_EXT_HI] = |src.ext[11:8];
  // serial, LIN, reload and housekeeping sources
  assign req_vec[REQ_SERIAL] = src.serial;
  assign req_vec[REQ_LIN_RX] = src.lin_rx;
  assign req_vec[REQ_LIN_TX] = src.lin_tx;
  assign req_vec[REQ_RELOAD] = src.reload;
  assign req_vec[REQ_P16_0] = src.p16_0;
  assign req_vec[REQ_I2C] = src.i2c;
  assign req_vec[REQ_P16_1] = src.p16_1;
  assign req_vec[REQ_ADC] = src.adc;
  assign req_vec[REQ_TIMEBASE] = src.timebase;
  assign req_vec[REQ_WATCH] = src.watch;
  assign req_vec[REQ_FLASH] = src.flash;
  // compound timer 0 halves side by side
  assign req_vec[REQ_CT0_LO] = src.ct0_lo;
  assign req_vec[REQ_CT0_HI] = src.ct0_hi;
  // compound timer 1 halves far apart in priority
  assign req_vec[REQ_CT1_HI] = src.ct1_hi;
  assign req_vec[REQ_CT1_LO] = src.ct1_lo;
  // pulse generator halves, channel 0 upper ahead of lower
  assign req_vec[REQ_PG1_LO] = src.pg1_lo;
  assign req_vec[REQ_PG1_HI] = src.pg1_hi;
  assign req_vec[REQ_PG0_HI] = src.pg0_hi;
  assign req_vec[REQ_PG0_LO] = src.pg0_lo;

  // four 2-bit fields per register, lowest request in the low bits
  generate
    for (g = 0; g < NUM_LVL_REG; g++) begin : g_flat
      assign lvl_flat[g*8 +: 8] = lvl_q[g];
    end
  endgenerate

  // address decode; the offset wraps so addresses below base miss
  assign addr_off = bus_addr - LVL_BASE_ADDR;
  assign addr_hit = addr_off < 16'(NUM_LVL_REG);
  assign addr_idx = addr_off[2:0];

  // level registers load from the core and reset to lowest level
  // writes outside the block are dropped, nothing else changes
  always_ff @(posedge clk) begin
    for (int k = 0; k < NUM_LVL_REG; k++) begin
      if (rst) begin
        lvl_q[k] <= LVL_RESET;
      end else if (bus_wr && addr_hit && addr_idx == 3'(k)) begin
        lvl_q[k] <= bus_wdata;
      end
    end
  end

  // unassigned reads answer a fixed value, software must not rely on it
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_rdata_q <= UNMAPPED_RDATA;
    end else if (bus_rd) begin
      bus_rdata_q <= addr_hit ? lvl_q[addr_idx] : UNMAPPED_RDATA;
    end
  end

  // best level first, lowest number among equals
  prio_pick u_pick (
    .req(req_vec),
    .lvl_flat(lvl_flat),
    .found(pick_found),
    .num(pick_num),
    .level(pick_level)
  );

  // vector falls two bytes per request number
  assign grant_d.valid = pick_found;
  assign grant_d.num = pick_num;
  assign grant_d.level = pick_level;
  assign grant_d.vector = VEC_TOP - 16'({pick_num, 1'b0});

  // registered grant costs one cycle of latency but keeps outputs clean
  always_ff @(posedge clk) begin
    if (rst) begin
      grant_q <= '0;
    end else begin
      grant_q <= grant_d;
    end
  end

  // helper copies of the inputs the grant was built from; they carry no
  // reset because every property that reads them is disabled in reset
  // and the grant register lags them by exactly the same edge
  logic [NUM_REQ-1:0] req_prev_q;
  logic [NUM_REQ*LVL_W-1:0] lvl_prev_q;
  logic [NUM_REQ-1:0] tie_lower;
  logic [NUM_REQ-1:0] better;
  always_ff @(posedge clk) begin
    req_prev_q <= req_vec;
    lvl_prev_q <= lvl_flat;
  end
  generate
    for (g = 0; g < NUM_REQ; g++) begin : g_chk
      assign tie_lower[g] = req_prev_q[g] && g < grant_q.num &&
        lvl_prev_q[g*LVL_W +: LVL_W] == grant_q.level;
      assign better[g] = req_prev_q[g] &&
        lvl_prev_q[g*LVL_W +: LVL_W] < grant_q.level;
    end
  endgenerate

  a_same_level_order: assert property (
    @(posedge clk) disable iff (rst) grant_q.valid |-> tie_lower == '0)
    else $error("lower numbered request at same level was passed over");
  a_level_field_use: assert property (
    @(posedge clk) disable iff (rst) grant_q.valid |-> better == '0 &&
      req_prev_q[grant_q.num] &&
      lvl_prev_q[grant_q.num*LVL_W +: LVL_W] == grant_q.level)
    else $error("grant does not match its level field");
  // only a lone upper half is sure to win: a higher number may still
  // hold a better level than this line
  a_ctimer0_map: assert property (
    @(posedge clk) disable iff (rst)
      req_vec == NUM_REQ'(1) << REQ_CT0_HI
      |=> grant_q.valid && grant_q.num == REQ_CT0_HI &&
      grant_q.vector == 16'hffee)
    else $error("compound timer 0 upper not on its line");
  a_ctimer1_map: assert property (
    @(posedge clk) disable iff (rst)
      grant_q.valid && grant_q.num == REQ_CT1_LO |-> $past(src.ct1_lo))
    else $error("compound timer 1 lower not on its line");
  a_pulse_gen_map: assert property (
    @(posedge clk) disable iff (rst)
      grant_q.valid && grant_q.num == REQ_PG0_HI |-> $past(src.pg0_hi))
    else $error("pulse generator channel 0 upper not on its line");
  a_misc_src_map: assert property (
    @(posedge clk) disable iff (rst)
      grant_q.valid && grant_q.num == REQ_FLASH |->
      $past(src.flash) && ($past(req_vec[REQ_FLASH-1:0]) == '0 ||
      $past(lvl_flat[REQ_FLASH*LVL_W +: LVL_W]) != 2'h3))
    else $error("flash request not on the last line");
  // software never writes outside the block, so reads reach this check
  a_unmapped_write: assert property (
    @(posedge clk) disable iff (rst) (bus_wr || bus_rd) && !addr_hit |=>
      lvl_flat == $past(lvl_flat))
    else $error("access outside the level block changed a field");
  a_vector_step: assert property (
    @(posedge clk) disable iff (rst) grant_q.valid |->
      grant_q.vector + 16'({grant_q.num, 1'b0}) == VEC_TOP)
    else $error("vector not two bytes per request below top");
  a_level_reset: assert property (
    @(posedge clk) rst ##1 !rst |-> lvl_flat == '1)
    else $error("level registers not all ones after reset");

  // lower half of compound timer 0 on its own line and vector
  a_ctimer0_lo_map: assert property (
    @(posedge clk) disable iff (rst)
      grant_q.valid && grant_q.num == REQ_CT0_LO |->
      $past(src.ct0_lo) && grant_q.vector == 16'hfff0)
    else $error("compound timer 0 lower not on its line");
  // channel 1 lower half of the pulse generator on its line
  a_pulse_gen_lo: assert property (
    @(posedge clk) disable iff (rst)
      grant_q.valid && grant_q.num == REQ_PG1_LO |-> $past(src.pg1_lo))
    else $error("pulse generator channel 1 lower not on its line");
  // reads outside the block answer the fixed filler byte
  a_unmapped_read: assert property (
    @(posedge clk) disable iff (rst) bus_rd && !addr_hit |=>
      bus_rdata_q == UNMAPPED_RDATA)
    else $error("read outside the level block returned a field");
  // valid tracks pending requests one cycle late; the edge after reset
  // is skipped since the grant register was held clear there
  a_grant_valid: assert property (
    @(posedge clk) disable iff (rst)
      !$past(rst) |-> grant_q.valid == $past(|req_vec))
    else $error("grant valid does not follow the pending requests");
  // the merged external line only wins when one of its channels asks
  a_ext_merge: assert property (
    @(posedge clk) disable iff (rst)
      grant_q.valid && grant_q.num == REQ_EXT_HI |-> $past(|src.ext[11:8]))
    else $error("merged external line granted without a request");

  c_tie_broken: cover property (@(posedge clk) disable iff (rst)
    grant_q.valid && $countones(req_prev_q) > 1);
  c_level_raise: cover property (@(posedge clk) disable iff (rst)
    grant_q.valid && grant_q.level == 2'h0 && grant_q.num > REQ_SERIAL);
  c_ext_shared: cover property (@(posedge clk) disable iff (rst)
    grant_q.valid && grant_q.num == REQ_EXT_HI);
  c_level_write: cover property (@(posedge clk) disable iff (rst)
    bus_wr && addr_hit);
  c_unmapped_read: cover property (@(posedge clk) disable iff (rst)
    bus_rd && !addr_hit);

endmodule // irq_vector_map

// file: req_source.sv
`timescale 1ns/1ps
module req_source
  import irq_map_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic [30:0] raise,
  input wire logic clr,
  // request levels toward the map
  output src_t src
);
  logic [30:0] src_q;
  logic [30:0] src_d;
  // a peripheral holds its request until serviced, never drops it early
  assign src_d = clr ? 31'h0 : (src_q | raise);
  always_ff @(posedge clk) begin
    if (rst) begin
      src_q <= 31'h0;
    end else begin
      src_q <= src_d;
    end
  end
  assign src = src_t'(src_q);
endmodule // req_source

// file: testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  import irq_map_pkg::*;
  localparam int TBL[19] = '{23, 22, 20, 19, 18, 17, 16, 15, 14, 13,
    12, 11, 10, 9, 8, 7, 6, 5, 4};
  logic clk, rst, bus_wr, bus_rd, clr;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata_q, d;
  logic [30:0] raise;
  logic [4:0] n;
  src_t src;
  grant_t grant_q;
  int fails, n_tests;

  irq_vector_map i_dut (.clk(clk), .rst(rst), .src(src),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q), .grant_q(grant_q));
  req_source i_src (.clk(clk), .rst(rst), .raise(raise), .clr(clr),
    .src(src));

  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // the bench only ever writes inside the level block
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    bus_addr = a; bus_wdata = v; bus_wr = 1'b1; step(1); bus_wr = 1'b0;
  endtask
  // data is registered, so it is read after the taking edge has landed
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    bus_addr = a; bus_rd = 1'b1; step(1); bus_rd = 1'b0; step(1);
    v = bus_rdata_q;
  endtask
  // source model adds one cycle, the grant register another
  task automatic pulse(input logic [30:0] r);
    raise = r; step(1); raise = 31'h0; step(2);
  endtask
  task automatic drop();
    clr = 1'b1; step(1); clr = 1'b0; step(2);
  endtask

  task automatic t_reset();
    for (int k = 0; k < 6; k++) begin
      rd(LVL_BASE_ADDR + 16'(k), d);
      `CHK(d, 8'hff)
    end
    `CHK(grant_q.valid, 1'b0)
  endtask

  // one source at a time, external lines shared per group
  task automatic t_map();
    for (int b = 0; b < 31; b++) begin
      if (b < 19) n = 5'(TBL[b]);
      else n = (b < 27) ? 5'((b - 19) % 4) : 5'h15;
      pulse(31'h1 << b);
      `CHK(grant_q.num, n)
      `CHK(grant_q.vector, 16'(VEC_TOP - 16'(2 * n)))
      `CHK(grant_q.level, 2'h3)
      drop();
      `CHK(grant_q.valid, 1'b0)
    end
  endtask

  // ties go to the lowest number; a raised level beats the order
  task automatic t_prio();
    pulse(31'h7fffffff);
    `CHK(grant_q.num, 5'h00)
    wr(16'h007e, 8'h3f);
    step(2);
    `CHK(grant_q.num, 5'h17)
    `CHK(grant_q.level, 2'h0)
    wr(16'h007a, 8'hf3);
    step(2);
    `CHK(grant_q.num, 5'h05)
    rd(16'h007e, d);
    `CHK(d, 8'h3f)
    rd(16'h007f, d);
    `CHK(d, UNMAPPED_RDATA)
    rd(16'h0078, d);
    `CHK(d, UNMAPPED_RDATA)
    drop();
  endtask

  // reset in mid-run with a request pending clears grant and levels
  task automatic t_rerst();
    pulse(31'h1 << 16);
    `CHK(grant_q.num, REQ_CT0_HI)
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(1);
    `CHK(grant_q.valid, 1'b0)
    t_reset();
  endtask

  task automatic print_verdict();
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    rst = 1'b1; bus_wr = 1'b0; bus_rd = 1'b0; clr = 1'b0;
    bus_addr = 16'h0000; bus_wdata = 8'h00; raise = 31'h0;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    step(1);
    t_reset();
    t_map();
    t_prio();
    t_rerst();
    print_verdict();
  end

  // tests need a few hundred cycles; a hang ends well after that
  initial begin
    #(50 * 2000);
    fails++;
    print_verdict();
  end
endmodule // testbench
